/* hdl/lat_l1_pkg.sv */
/*
  Constants and carrier types for the latency-limit and L1 substate
  configuration bank. Assumes byte addressing of 32-bit dwords.
*/
package lat_l1_pkg;

  localparam int          ADDR_W = 12;
  localparam int          DATA_W = 32;

  // Dword byte offsets
  localparam logic [11:0] OFF_LTR_HDR    = 12'h230;
  localparam logic [11:0] OFF_LTR_LIMITS = 12'h234;
  localparam logic [11:0] OFF_L1_HDR     = 12'h240;
  localparam logic [11:0] OFF_L1_CAP     = 12'h244;
  localparam logic [11:0] OFF_L1_CTL1    = 12'h248;
  localparam logic [11:0] OFF_L1_CTL2    = 12'h24c;
  localparam logic [11:0] OFF_LINK_STATE = 12'h33c;

  // Extended capability header contents
  localparam logic [15:0] LTR_CAP_ID     = 16'h0018;
  localparam logic [15:0] L1_CAP_ID      = 16'h001e;
  localparam logic [3:0]  CAP_VERSION    = 4'h1;
  localparam logic [11:0] LTR_NEXT_PTR   = 12'h240;
  localparam logic [11:0] L1_NEXT_PTR    = 12'h000;

  // Field positions
  localparam int          SNOOP_VAL_LSB   = 0;
  localparam int          SNOOP_SCALE_LSB = 10;
  localparam int          NOSNP_VAL_LSB   = 16;
  localparam int          NOSNP_SCALE_LSB = 26;
  localparam int          PCIPM_L11_BIT   = 1;
  localparam int          ASPM_L11_BIT    = 3;
  localparam int          L1SS_SUP_BIT    = 4;
  localparam int          ID_LSB          = 0;
  localparam int          VER_LSB         = 16;
  localparam int          NEXT_LSB        = 20;

  // Reset values
  localparam logic [9:0]  LAT_VAL_RST     = 10'h000;
  localparam logic [2:0]  LAT_SCALE_RST   = 3'h0;
  localparam logic        PCIPM_SUP_RST   = 1'b1;
  localparam logic        ASPM_SUP_RST    = 1'b0;
  localparam logic        L1SS_SUP_RST    = 1'b1;
  localparam logic        ENABLE_RST      = 1'b0;
  localparam logic [7:0]  LINK_STATE_RST  = 8'h00;
  localparam logic [31:0] CTL2_VALUE      = 32'h0000_0000;

  typedef struct packed {
    logic [2:0] nosnoop_scale;
    logic [9:0] nosnoop_val;
    logic [2:0] snoop_scale;
    logic [9:0] snoop_val;
  } lat_limits_s;

  typedef struct packed {
    logic       pcipm_l11_sup;
    logic       aspm_l11_sup;
    logic       l1ss_sup;
    logic [7:0] link_state;
  } default_load_s;

  typedef struct packed {
    logic pcipm_l11_en;
    logic aspm_l11_en;
  } l1_enables_s;

endpackage

/* hdl/latency_and_l1_substate_cfg.sv */
/*
  Configuration register bank: latency tolerance limits capability
  (upstream port only), L1 PM substates capability and a link training
  state view. Assumes a single-cycle strobe master on clk_i with read
  data taken in the cycle after the read strobe; external default
  loading arrives as a one-cycle strobe with its data.
*/
// The implementer's own choice: the strobed register port.
// Functional notes
// - Latency header exists only on upstream port; bits 15:0 read 0018h.
// - Both capability headers read version 1 in bits 19:16.
// - Latency header next pointer reads 240h in bits 31:20.
// - Max snoop latency value bits 9:0 read-write, reset zero.
// - Max snoop latency scale bits 12:10 read-write, reset zero.
// - Max no-snoop latency value bits 25:16 read-write, reset zero.
// - Max no-snoop latency scale bits 28:26 read-write, reset zero.
// - L1 substates header bits 15:0 read 001Eh.
// - L1 substates header next pointer reads zero, ending the list.
// - Capability bit 1 PCI-PM L1.1 support, reset one, externally loadable.
// - Capability bit 3 ASPM L1.1 support, reset zero, externally loadable.
// - Capability bit 4 substates support, reset one, externally loadable.
// - Control bit 1 PCI-PM L1.1 enable, read-write, reset zero.
// - Control bit 3 ASPM L1.1 enable, read-write, reset zero.
// - Second control dword reads all zeros, writes ignored.
// - Link state bits 7:0 read-only, reset zero, externally loadable.
`timescale 1ns/10ps

module latency_and_l1_substate_cfg #(
  parameter bit UPSTREAM = 1'b1
) (
  input  wire logic                         clk_i,
  input  wire logic                         nrst_i,
  input  wire logic [lat_l1_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [lat_l1_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic      [lat_l1_pkg::DATA_W-1:0] rdata_o,
  input  wire logic                         load_i,
  input  wire lat_l1_pkg::default_load_s    load_data_i,
  input  wire logic                         state_upd_i,
  input  wire logic [7:0]                   state_i,
  output lat_l1_pkg::lat_limits_s           lat_limits_o,
  output lat_l1_pkg::l1_enables_s           l1_enables_o
);

  logic                      cap_pcipm_q;
  logic                      cap_aspm_q;
  logic                      cap_l1ss_q;
  logic [7:0]                link_state_q;
  logic [31:0]               rdata_d;

  // Dword match; low two address bits are byte lanes and ignored
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  // Any dword the bank decodes; everything else reads zero
  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, lat_l1_pkg::OFF_LTR_HDR) || hit(a, lat_l1_pkg::OFF_LTR_LIMITS)
          || hit(a, lat_l1_pkg::OFF_L1_HDR) || hit(a, lat_l1_pkg::OFF_L1_CAP)
          || hit(a, lat_l1_pkg::OFF_L1_CTL1) || hit(a, lat_l1_pkg::OFF_L1_CTL2)
          || hit(a, lat_l1_pkg::OFF_LINK_STATE);
  endfunction

  // Latency limits: only writable bits are stored, reserved bits dropped
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lat_limits_o.snoop_val     <= lat_l1_pkg::LAT_VAL_RST;
      lat_limits_o.snoop_scale   <= lat_l1_pkg::LAT_SCALE_RST;
      lat_limits_o.nosnoop_val   <= lat_l1_pkg::LAT_VAL_RST;
      lat_limits_o.nosnoop_scale <= lat_l1_pkg::LAT_SCALE_RST;
    end else if (UPSTREAM && wr_i && hit(addr_i, lat_l1_pkg::OFF_LTR_LIMITS)) begin
      lat_limits_o.snoop_val     <= wdata_i[lat_l1_pkg::SNOOP_VAL_LSB +: 10];
      lat_limits_o.snoop_scale   <= wdata_i[lat_l1_pkg::SNOOP_SCALE_LSB +: 3];
      lat_limits_o.nosnoop_val   <= wdata_i[lat_l1_pkg::NOSNP_VAL_LSB +: 10];
      lat_limits_o.nosnoop_scale <= wdata_i[lat_l1_pkg::NOSNP_SCALE_LSB +: 3];
    end
  end

  // Substate enables steer the port's power management logic
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      l1_enables_o.pcipm_l11_en <= lat_l1_pkg::ENABLE_RST;
      l1_enables_o.aspm_l11_en  <= lat_l1_pkg::ENABLE_RST;
    end else if (wr_i && hit(addr_i, lat_l1_pkg::OFF_L1_CTL1)) begin
      l1_enables_o.pcipm_l11_en <= wdata_i[lat_l1_pkg::PCIPM_L11_BIT];
      l1_enables_o.aspm_l11_en  <= wdata_i[lat_l1_pkg::ASPM_L11_BIT];
    end
  end

  // Support bits: read-only to software, only the default loader changes them
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cap_pcipm_q <= lat_l1_pkg::PCIPM_SUP_RST;
      cap_aspm_q  <= lat_l1_pkg::ASPM_SUP_RST;
      cap_l1ss_q  <= lat_l1_pkg::L1SS_SUP_RST;
    end else if (load_i) begin
      cap_pcipm_q <= load_data_i.pcipm_l11_sup;
      cap_aspm_q  <= load_data_i.aspm_l11_sup;
      cap_l1ss_q  <= load_data_i.l1ss_sup;
    end
  end

  // Loader wins over a live update in the same cycle: defaults are rare
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      link_state_q <= lat_l1_pkg::LINK_STATE_RST;
    end else if (load_i) begin
      link_state_q <= load_data_i.link_state;
    end else if (state_upd_i) begin
      link_state_q <= state_i;
    end
  end

  // Read decode; unmapped offsets and reserved bits read zero
  always_comb begin
    rdata_d = '0;
    if (hit(addr_i, lat_l1_pkg::OFF_LTR_HDR)) begin
      if (UPSTREAM) begin
        rdata_d[lat_l1_pkg::ID_LSB +: 16]  = lat_l1_pkg::LTR_CAP_ID;
        rdata_d[lat_l1_pkg::VER_LSB +: 4]  = lat_l1_pkg::CAP_VERSION;
        rdata_d[lat_l1_pkg::NEXT_LSB +: 12] = lat_l1_pkg::LTR_NEXT_PTR;
      end
    end else if (hit(addr_i, lat_l1_pkg::OFF_LTR_LIMITS)) begin
      if (UPSTREAM) begin
        rdata_d[lat_l1_pkg::SNOOP_VAL_LSB +: 10]  = lat_limits_o.snoop_val;
        rdata_d[lat_l1_pkg::SNOOP_SCALE_LSB +: 3] = lat_limits_o.snoop_scale;
        rdata_d[lat_l1_pkg::NOSNP_VAL_LSB +: 10]  = lat_limits_o.nosnoop_val;
        rdata_d[lat_l1_pkg::NOSNP_SCALE_LSB +: 3] = lat_limits_o.nosnoop_scale;
      end
    end else if (hit(addr_i, lat_l1_pkg::OFF_L1_HDR)) begin
      rdata_d[lat_l1_pkg::ID_LSB +: 16]   = lat_l1_pkg::L1_CAP_ID;
      rdata_d[lat_l1_pkg::VER_LSB +: 4]   = lat_l1_pkg::CAP_VERSION;
      rdata_d[lat_l1_pkg::NEXT_LSB +: 12] = lat_l1_pkg::L1_NEXT_PTR;
    end else if (hit(addr_i, lat_l1_pkg::OFF_L1_CAP)) begin
      rdata_d[lat_l1_pkg::PCIPM_L11_BIT] = cap_pcipm_q;
      rdata_d[lat_l1_pkg::ASPM_L11_BIT]  = cap_aspm_q;
      rdata_d[lat_l1_pkg::L1SS_SUP_BIT]  = cap_l1ss_q;
    end else if (hit(addr_i, lat_l1_pkg::OFF_L1_CTL1)) begin
      rdata_d[lat_l1_pkg::PCIPM_L11_BIT] = l1_enables_o.pcipm_l11_en;
      rdata_d[lat_l1_pkg::ASPM_L11_BIT]  = l1_enables_o.aspm_l11_en;
    end else if (hit(addr_i, lat_l1_pkg::OFF_L1_CTL2)) begin
      rdata_d = lat_l1_pkg::CTL2_VALUE;
    end else if (hit(addr_i, lat_l1_pkg::OFF_LINK_STATE)) begin
      rdata_d[7:0] = link_state_q;
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rdata_d;
    end else begin
      rdata_o <= '0;
    end
  end

  AST_LTR_HDR_ID: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && hit(addr_i, lat_l1_pkg::OFF_LTR_HDR) |=>
      rdata_o[15:0] == (UPSTREAM ? lat_l1_pkg::LTR_CAP_ID : 16'h0000))
    else $error("latency header id wrong");

  AST_HDR_VERSION: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && hit(addr_i, lat_l1_pkg::OFF_L1_HDR) |=> rdata_o[19:16] == lat_l1_pkg::CAP_VERSION)
    else $error("capability version not one");

  AST_LTR_NEXT: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && UPSTREAM && hit(addr_i, lat_l1_pkg::OFF_LTR_HDR)
      |=> rdata_o[31:20] == lat_l1_pkg::LTR_NEXT_PTR)
    else $error("latency next pointer wrong");

  AST_SNOOP_WRITE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_i && UPSTREAM && hit(addr_i, lat_l1_pkg::OFF_LTR_LIMITS) ##1 rd_i && $stable(addr_i)
      |=> rdata_o[12:0] == $past(wdata_i[12:0], 2))
    else $error("snoop limit not written back");

  AST_NOSNOOP_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(wr_i && hit(addr_i, lat_l1_pkg::OFF_LTR_LIMITS)) |=> $stable(lat_limits_o))
    else $error("latency limits changed without a write");

  AST_NOSNOOP_SCALE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_i && UPSTREAM && hit(addr_i, lat_l1_pkg::OFF_LTR_LIMITS)
      |=> lat_limits_o.nosnoop_scale == $past(wdata_i[28:26])
          && lat_limits_o.nosnoop_val == $past(wdata_i[25:16]))
    else $error("no-snoop limit wrong");

  AST_L1_HDR: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && hit(addr_i, lat_l1_pkg::OFF_L1_HDR)
      |=> rdata_o == {lat_l1_pkg::L1_NEXT_PTR, lat_l1_pkg::CAP_VERSION, lat_l1_pkg::L1_CAP_ID})
    else $error("substates header wrong");

  AST_CAP_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    load_i ##1 rd_i && hit(addr_i, lat_l1_pkg::OFF_L1_CAP)
      |=> rdata_o == {27'h0, $past(load_data_i.l1ss_sup, 2), $past(load_data_i.aspm_l11_sup, 2),
                      1'b0, $past(load_data_i.pcipm_l11_sup, 2), 1'b0})
    else $error("capability bits not loaded");

  AST_ENABLES: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_i && hit(addr_i, lat_l1_pkg::OFF_L1_CTL1) |=>
      l1_enables_o == {$past(wdata_i[1]), $past(wdata_i[3])})
    else $error("substate enables not written");

  AST_CTL2_ZERO: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && hit(addr_i, lat_l1_pkg::OFF_L1_CTL2) |=> rdata_o == 32'h0)
    else $error("control two not zero");

  AST_LINK_STATE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && hit(addr_i, lat_l1_pkg::OFF_LINK_STATE) |=>
      rdata_o[31:8] == 24'h0 && rdata_o[7:0] == $past(link_state_q))
    else $error("link state readback wrong");

  AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && hit(addr_i, lat_l1_pkg::OFF_LTR_LIMITS) |=>
      rdata_o[15:13] == 3'h0 && rdata_o[31:29] == 3'h0)
    else $error("reserved latency bits not zero");

  // Defaults seen at the first edge after reset release
  AST_SNOOP_VAL_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> lat_limits_o.snoop_val == lat_l1_pkg::LAT_VAL_RST)
    else $error("snoop value not reset");

  AST_SNOOP_SCALE_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> lat_limits_o.snoop_scale == lat_l1_pkg::LAT_SCALE_RST)
    else $error("snoop scale not reset");

  AST_NOSNOOP_VAL_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> lat_limits_o.nosnoop_val == lat_l1_pkg::LAT_VAL_RST)
    else $error("no-snoop value not reset");

  AST_NOSNOOP_SCALE_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> lat_limits_o.nosnoop_scale == lat_l1_pkg::LAT_SCALE_RST)
    else $error("no-snoop scale not reset");

  AST_PCIPM_SUP_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> cap_pcipm_q == lat_l1_pkg::PCIPM_SUP_RST)
    else $error("pci-pm support not reset");

  AST_ASPM_SUP_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> cap_aspm_q == lat_l1_pkg::ASPM_SUP_RST)
    else $error("aspm support not reset");

  AST_L1SS_SUP_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> cap_l1ss_q == lat_l1_pkg::L1SS_SUP_RST)
    else $error("substates support not reset");

  AST_PCIPM_EN_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> l1_enables_o.pcipm_l11_en == lat_l1_pkg::ENABLE_RST)
    else $error("pci-pm enable not reset");

  AST_ASPM_EN_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> l1_enables_o.aspm_l11_en == lat_l1_pkg::ENABLE_RST)
    else $error("aspm enable not reset");

  AST_LINK_STATE_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> link_state_q == lat_l1_pkg::LINK_STATE_RST)
    else $error("link state not reset");

  AST_RDATA_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> rdata_o == '0)
    else $error("read data not reset");

  // Capability headers and downstream latency limits
  AST_LTR_VERSION: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && UPSTREAM && hit(addr_i, lat_l1_pkg::OFF_LTR_HDR)
      |=> rdata_o[19:16] == lat_l1_pkg::CAP_VERSION)
    else $error("latency header version not one");

  AST_LTR_HDR_GONE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && !UPSTREAM && hit(addr_i, lat_l1_pkg::OFF_LTR_HDR) |=> rdata_o == '0)
    else $error("latency header seen on downstream port");

  AST_LIMITS_GONE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && !UPSTREAM && hit(addr_i, lat_l1_pkg::OFF_LTR_LIMITS) |=> rdata_o == '0)
    else $error("latency limits seen on downstream port");

  AST_DN_LIMITS_FIXED: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !UPSTREAM |-> lat_limits_o == '0)
    else $error("downstream latency limits changed");

  AST_L1_ID: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && hit(addr_i, lat_l1_pkg::OFF_L1_HDR) |=> rdata_o[15:0] == lat_l1_pkg::L1_CAP_ID)
    else $error("substates id wrong");

  AST_L1_NEXT: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && hit(addr_i, lat_l1_pkg::OFF_L1_HDR) |=> rdata_o[31:20] == lat_l1_pkg::L1_NEXT_PTR)
    else $error("substates next pointer not zero");

  // Latency limits
  AST_SNOOP_VAL_WR: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_i && UPSTREAM && hit(addr_i, lat_l1_pkg::OFF_LTR_LIMITS)
      |=> lat_limits_o.snoop_val == $past(wdata_i[9:0]))
    else $error("snoop value not written");

  AST_SNOOP_SCALE_WR: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_i && UPSTREAM && hit(addr_i, lat_l1_pkg::OFF_LTR_LIMITS)
      |=> lat_limits_o.snoop_scale == $past(wdata_i[12:10]))
    else $error("snoop scale not written");

  AST_SNOOP_READBACK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && UPSTREAM && hit(addr_i, lat_l1_pkg::OFF_LTR_LIMITS)
      |=> rdata_o[12:0] == $past({lat_limits_o.snoop_scale, lat_limits_o.snoop_val}))
    else $error("snoop limit readback wrong");

  AST_NOSNOOP_READBACK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && UPSTREAM && hit(addr_i, lat_l1_pkg::OFF_LTR_LIMITS)
      |=> rdata_o[28:16] == $past({lat_limits_o.nosnoop_scale, lat_limits_o.nosnoop_val}))
    else $error("no-snoop limit readback wrong");

  // Substate enables and support bits
  AST_ENABLES_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !(wr_i && hit(addr_i, lat_l1_pkg::OFF_L1_CTL1)) |=> $stable(l1_enables_o))
    else $error("enables changed without a write");

  AST_ASPM_EN_WR: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_i && hit(addr_i, lat_l1_pkg::OFF_L1_CTL1)
      |=> l1_enables_o.aspm_l11_en == $past(wdata_i[lat_l1_pkg::ASPM_L11_BIT]))
    else $error("aspm enable not written");

  AST_CTL1_READBACK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && hit(addr_i, lat_l1_pkg::OFF_L1_CTL1)
      |=> rdata_o == {28'h0, $past(l1_enables_o.aspm_l11_en), 1'b0,
                      $past(l1_enables_o.pcipm_l11_en), 1'b0})
    else $error("control one readback wrong");

  AST_CTL1_RSVD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && hit(addr_i, lat_l1_pkg::OFF_L1_CTL1) |=> rdata_o[31:4] == 28'h0)
    else $error("control one reserved bits set");

  AST_CAPS_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !load_i |=> $stable({cap_pcipm_q, cap_aspm_q, cap_l1ss_q}))
    else $error("support bits changed without a load");

  AST_CAPS_READBACK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && hit(addr_i, lat_l1_pkg::OFF_L1_CAP) |=> rdata_o ==
      {27'h0, $past(cap_l1ss_q), $past(cap_aspm_q), 1'b0, $past(cap_pcipm_q), 1'b0})
    else $error("capability readback wrong");

  AST_PCIPM_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    load_i |=> cap_pcipm_q == $past(load_data_i.pcipm_l11_sup))
    else $error("pci-pm support not loaded");

  AST_ASPM_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    load_i |=> cap_aspm_q == $past(load_data_i.aspm_l11_sup))
    else $error("aspm support not loaded");

  AST_L1SS_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    load_i |=> cap_l1ss_q == $past(load_data_i.l1ss_sup))
    else $error("substates support not loaded");

  // Link state view and read port
  AST_LINK_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    load_i && !state_upd_i |=> link_state_q == $past(load_data_i.link_state))
    else $error("link state not loaded");

  AST_LOAD_OVER_UPDATE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    load_i && state_upd_i |=> link_state_q == $past(load_data_i.link_state))
    else $error("live update beat the loader");

  AST_LINK_UPD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state_upd_i && !load_i |=> link_state_q == $past(state_i))
    else $error("live link state not taken");

  AST_LINK_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !load_i && !state_upd_i |=> $stable(link_state_q))
    else $error("link state changed on its own");

  AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !rd_i |=> rdata_o == '0)
    else $error("read data outside the read slot");

  AST_UNMAPPED_ZERO: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && !mapped(addr_i) |=> rdata_o == '0)
    else $error("unmapped read not zero");

  AST_CAP_RSVD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rd_i && hit(addr_i, lat_l1_pkg::OFF_L1_CAP) |=> rdata_o[31:5] == 27'h0)
    else $error("capability reserved bits set");

endmodule // latency_and_l1_substate_cfg

/* tb/testbench.sv */
/*
  Self-checking bench for the latency-limit and L1 substate bank.
  Assumes the bank's single-cycle strobe bus; a downstream copy shares inputs.
*/
`timescale 1ns/10ps

module testbench;
  logic                          clk_i       = 1'b0;
  logic                          nrst_i      = 1'b0;
  logic [11:0]                   addr_i      = 12'h000;
  logic [31:0]                   wdata_i     = 32'h0000_0000;
  logic                          wr_i        = 1'b0;
  logic                          rd_i        = 1'b0;
  logic                          load_i      = 1'b0;
  lat_l1_pkg::default_load_s     load_data_i = '0;
  logic                          state_upd_i = 1'b0;
  logic [7:0]                    state_i     = 8'h00;
  logic [31:0]                   rdata_o;
  logic [31:0]                   dn_rdata;
  lat_l1_pkg::lat_limits_s       lat_limits_o;
  lat_l1_pkg::l1_enables_s       l1_enables_o;
  logic [31:0]                   got;
  int                            fails           = 0;
  int                            samples_checked = 0;

  always #5 clk_i = ~clk_i;

  latency_and_l1_substate_cfg #(.UPSTREAM(1'b1)) latency_and_l1_substate_cfg_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .load_i(load_i), .load_data_i(load_data_i),
    .state_upd_i(state_upd_i), .state_i(state_i), .lat_limits_o(lat_limits_o),
    .l1_enables_o(l1_enables_o));
  // Downstream copy: latency capability must vanish
  latency_and_l1_substate_cfg #(.UPSTREAM(1'b0)) dn_cfg_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(dn_rdata), .load_i(load_i), .load_data_i(load_data_i),
    .state_upd_i(state_upd_i), .state_i(state_i), .lat_limits_o(), .l1_enables_o());

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    rd(a, got);
    chk(what, exp, got);
  endtask

  task automatic reset_values();
    rd_chk("latency header", 12'h230, 32'h2401_0018);
    chk("downstream latency header", 32'h0, dn_rdata);
    rd_chk("latency limits", 12'h234, 32'h0);
    rd_chk("substates header", 12'h240, 32'h0001_001e);
    rd_chk("substates caps", 12'h244, 32'h0000_0012);
    rd_chk("control one", 12'h248, 32'h0);
    rd_chk("control two", 12'h24c, 32'h0);
    rd_chk("link state", 12'h33c, 32'h0);
    @(posedge clk_i);
    #1;
    chk("read data after slot", 32'h0, rdata_o);
  endtask

  task automatic limits_rw();
    logic [31:0] pat [2];
    pat[0] = 32'hffff_ffff;
    pat[1] = 32'h1234_5678;
    for (int i = 0; i < 2; i++) begin
      wr(12'h234, pat[i]);
      #1;
      chk("limits out", {6'h00, pat[i][28:16], pat[i][12:0]}, 32'(lat_limits_o));
      rd_chk("limits", 12'h234, pat[i] & 32'h1fff_1fff);
      chk("downstream limits", 32'h0, dn_rdata);
    end
  endtask

  task automatic control_and_ro();
    wr(12'h248, 32'hffff_ffff);
    #1;
    chk("enables out", 32'h3, 32'(l1_enables_o));
    rd_chk("control one", 12'h248, 32'h0000_000a);
    wr(12'h24c, 32'hffff_ffff);
    rd_chk("control two", 12'h24c, 32'h0);
    wr(12'h230, 32'h0);
    rd_chk("latency header", 12'h230, 32'h2401_0018);
    wr(12'h244, 32'h0);
    rd_chk("substates caps", 12'h244, 32'h0000_0012);
    wr(12'h33c, 32'hffff_ffff);
    rd_chk("link state", 12'h33c, 32'h0);
    wr(12'h100, 32'hffff_ffff);
    rd_chk("unmapped", 12'h100, 32'h0);
  endtask

  // Load must beat a live update arriving in the same cycle
  task automatic external_load();
    @(posedge clk_i);
    load_i      <= 1'b1;
    load_data_i <= '{pcipm_l11_sup: 1'b0, aspm_l11_sup: 1'b1, l1ss_sup: 1'b0, link_state: 8'ha5};
    state_upd_i <= 1'b1;
    state_i     <= 8'h3c;
    @(posedge clk_i);
    load_i      <= 1'b0;
    state_upd_i <= 1'b0;
    rd_chk("loaded caps", 12'h244, 32'h0000_0008);
    rd_chk("loaded link state", 12'h33c, 32'h0000_00a5);
    @(posedge clk_i);
    state_upd_i <= 1'b1;
    @(posedge clk_i);
    state_upd_i <= 1'b0;
    rd_chk("live link state", 12'h33c, 32'h0000_003c);
  endtask

  // No gap between strobes: write then read, load then read
  task automatic back_to_back();
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= 12'h234;
    wdata_i <= 32'h0c01_1802;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i        <= 1'b0;
    load_i      <= 1'b1;
    load_data_i <= '{pcipm_l11_sup: 1'b1, aspm_l11_sup: 1'b1, l1ss_sup: 1'b1, link_state: 8'h5a};
    #1;
    chk("limits after write", 32'h0c01_1802, rdata_o);
    @(posedge clk_i);
    load_i <= 1'b0;
    rd_i   <= 1'b1;
    addr_i <= 12'h244;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("caps after load", 32'h0000_001a, rdata_o);
  endtask

  // Reset in mid-run must restore every written default
  task automatic mid_reset();
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd_chk("limits after reset", 12'h234, 32'h0);
    rd_chk("caps after reset", 12'h244, 32'h0000_0012);
    rd_chk("control one after reset", 12'h248, 32'h0);
    rd_chk("link state after reset", 12'h33c, 32'h0);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    reset_values();
    limits_rw();
    control_and_ro();
    external_load();
    back_to_back();
    mid_reset();
    close_out();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    fails++;
    close_out();
  end
endmodule // testbench
